// File: hw/bldc_counter.sv
// Purpose: Batch, cutting-length and roll-diameter counting with AXI4-Lite registers.
// Assumes: enc1_step is a one-cycle scaled impulse strobe; all inputs synchronous to aclk.
// Notes:   Diameter arithmetic is external: rev_count/rev_strobe out, diam_* back in.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`include "bldc_defines.svh"
`default_nettype none
module bldc_counter
  import bldc_pkg::*;
#(
  parameter int TICK_CYCLES = `BLDC_TICK_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        enc1_step,
  input  wire logic        enc1_down,
  input  wire logic        enc2_step,
  input  wire logic        control_input_one,
  input  wire logic        control_input_two,
  input  wire logic        key_input,
  input  wire logic        roll_trigger,
  input  wire logic        diam_valid,
  input  wire logic [31:0] diam_full,
  output logic [31:0]      rev_count,
  output logic             rev_strobe,
  output logic [31:0]      final_scaling_multiplier,
  output logic [31:0]      final_scaling_divider,
  output logic             preset_output_one,
  output logic             preset_output_two,
  output logic             preset_output_three,
  output logic             preset_output_four
);

  bldc_state_t s_r;
  bldc_state_t s_nxt;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic edge_of(input logic cur, input logic prev, input logic fall);
    return fall ? (prev & ~cur) : (cur & ~prev);
  endfunction

  // Encoder channel 2 plays no part in modes 3 to 5.
  logic enc2_unused;
  assign enc2_unused = enc2_step;

  logic        c1_edge;
  logic        c2_edge;
  logic        key_edge;
  logic        trig_edge;
  logic        batch_mode;
  logic        len_mode;
  logic        diam_mode;
  logic        restart_on;
  logic        batch_inc;
  logic        batch_dec;
  logic        do_reset;
  logic        wr_do;
  logic        rd_do;
  logic        tick_now;
  logic [31:0] tracked;
  logic [31:0] src12;
  logic [31:0] src34;
  logic [31:0] status_w;
  logic [31:0] diam_shown;

  always_comb begin
    s_nxt      = s_r;
    c1_edge    = edge_of(control_input_one, s_r.prev_c1, s_r.edge1_fall);
    c2_edge    = edge_of(control_input_two, s_r.prev_c2, s_r.edge2_fall);
    key_edge   = key_input & ~s_r.prev_key;
    trig_edge  = roll_trigger & ~s_r.prev_trig;
    batch_mode = (s_r.mode == `BLDC_MODE_BATCH);
    len_mode   = (s_r.mode == `BLDC_MODE_LENGTH);
    diam_mode  = (s_r.mode == `BLDC_MODE_DIAM);
    restart_on = (s_r.restart == `BLDC_RESTART_A) || (s_r.restart == `BLDC_RESTART_B);
    batch_inc  = 1'b0;
    batch_dec  = 1'b0;
    do_reset   = 1'b0;
    tick_now   = (s_r.tick >= 32'(TICK_CYCLES - 1));
    diam_shown = (s_r.core == 32'h00000000) ? diam_full : (diam_full - s_r.core);
    wr_do      = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    rd_do      = s_axi_arvalid && !s_r.rvalid;
    s_nxt.prev_c1    = control_input_one;
    s_nxt.prev_c2    = control_input_two;
    s_nxt.prev_key   = key_input;
    s_nxt.prev_trig  = roll_trigger;
    s_nxt.rev_strobe = 1'b0;
    s_nxt.tick       = tick_now ? 32'h00000000 : (s_r.tick + 32'h00000001);

    // Counting per operating mode.
    if (batch_mode) begin
      if (enc1_step) begin
        if (s_r.rev) begin
          if (s_r.master == 32'h00000001 || s_r.master == 32'h00000000) begin
            s_nxt.master = restart_on ? s_r.preset[0] : 32'h00000000;
            batch_inc    = 1'b1;
          end else begin
            s_nxt.master = s_r.master - 32'h00000001;
          end
        end else if ($signed(s_r.master + 32'h00000001) >= $signed(s_r.preset[0])) begin
          s_nxt.master = restart_on ? 32'h00000000 : (s_r.master + 32'h00000001);
          batch_inc    = 1'b1;
        end else begin
          s_nxt.master = s_r.master + 32'h00000001;
        end
      end
      batch_dec = (c1_edge && s_r.asg1 == `BLDC_CMD_BATCH_DEC)
               || (c2_edge && s_r.asg2 == `BLDC_CMD_BATCH_DEC)
               || (key_edge && s_r.asgk == `BLDC_CMD_BATCH_DEC);
      if (batch_inc && !batch_dec) begin
        s_nxt.batch = s_r.batch + 32'h00000001;
      end else if (batch_dec && !batch_inc) begin
        s_nxt.batch = s_r.batch - 32'h00000001;
      end
    end else if (len_mode) begin
      // Latch on the stop event; without start/stop the live counter restarts at zero at once, with it the count holds until input one starts it.
      if (!s_r.startstop) begin
        if (c1_edge) begin
          s_nxt.latched = s_r.master;
          s_nxt.master  = enc1_step ? 32'h00000001 : 32'h00000000;
        end else if (enc1_step) begin
          s_nxt.master = s_r.master + 32'h00000001;
        end
        s_nxt.running = 1'b1;
      end else begin
        if (c2_edge && s_r.running) begin
          s_nxt.latched = s_r.master;
          s_nxt.running = 1'b0;
        end else if (c1_edge) begin
          s_nxt.master  = 32'h00000000;
          s_nxt.running = 1'b1;
        end else if (enc1_step && s_r.running) begin
          s_nxt.master = s_r.master + 32'h00000001;
        end
      end
    end else if (diam_mode) begin
      if (enc1_step) begin
        s_nxt.master = enc1_down ? (s_r.master - 32'h00000001) : (s_r.master + 32'h00000001);
      end
      if (trig_edge) begin
        s_nxt.rev_count  = s_r.master - s_r.line_last;
        s_nxt.line_last  = s_r.master;
        s_nxt.rev_strobe = 1'b1;
      end
      if (diam_valid) begin
        s_nxt.diam = diam_shown;
      end
    end else if (enc1_step) begin
      s_nxt.master = enc1_down ? (s_r.master - 32'h00000001) : (s_r.master + 32'h00000001);
    end

    // Value whose extremes are recorded and shown on the display register.
    if (batch_mode) begin
      tracked = s_r.batch;
    end else if (len_mode) begin
      tracked = s_r.latched;
    end else begin
      tracked = s_r.diam;
    end
    if (tick_now && (batch_mode || (len_mode && s_r.running) || diam_mode)) begin
      if (!s_r.mm_valid || $signed(tracked) < $signed(s_r.minv)) begin
        s_nxt.minv = tracked;
      end
      if (!s_r.mm_valid || $signed(tracked) > $signed(s_r.maxv)) begin
        s_nxt.maxv = tracked;
      end
      s_nxt.mm_valid = 1'b1;
    end

    if (batch_mode || len_mode || diam_mode) begin
      src12 = s_r.master;
      src34 = tracked;
    end else begin
      src12 = s_r.master;
      src34 = s_r.master;
    end
    s_nxt.kout[0] = $signed(src12) >= $signed(s_r.preset[0]);
    s_nxt.kout[1] = $signed(src12) >= $signed(s_r.preset[1]);
    s_nxt.kout[2] = $signed(src34) >= $signed(s_r.preset[2]);
    s_nxt.kout[3] = $signed(src34) >= $signed(s_r.preset[3]);

    status_w = {26'h0000000, s_r.mm_valid, s_r.running, s_r.kout};

    // Write channel: address and data taken in either order, answer after both.
    if (s_axi_awvalid && !s_r.aw_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_got && !s_r.bvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_do) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = `BLDC_RESP_OKAY;
      if (s_r.awaddr == `BLDC_OFS_CTRL) begin
        s_nxt.restart    = s_r.wstrb[0] ? s_r.wdata[`BLDC_CTRL_RESTART_LSB +: 3] : s_r.restart;
        s_nxt.rev        = s_r.wstrb[1] ? s_r.wdata[`BLDC_CTRL_REVERSE] : s_r.rev;
        s_nxt.edge1_fall = s_r.wstrb[1] ? s_r.wdata[`BLDC_CTRL_EDGE1_FALL] : s_r.edge1_fall;
        s_nxt.edge2_fall = s_r.wstrb[1] ? s_r.wdata[`BLDC_CTRL_EDGE2_FALL] : s_r.edge2_fall;
        s_nxt.startstop  = s_r.wstrb[1] ? s_r.wdata[`BLDC_CTRL_STARTSTOP] : s_r.startstop;
        if (!s_r.wstrb[0]) begin
          s_nxt.mode = s_r.mode;
        end else begin
          s_nxt.mode = s_r.wdata[`BLDC_CTRL_MODE_LSB +: 4];
        end
      end else if (s_r.awaddr == `BLDC_OFS_ASSIGN) begin
        s_nxt.asg1 = s_r.wstrb[0] ? s_r.wdata[7:0] : s_r.asg1;
        s_nxt.asg2 = s_r.wstrb[1] ? s_r.wdata[15:8] : s_r.asg2;
        s_nxt.asgk = s_r.wstrb[2] ? s_r.wdata[23:16] : s_r.asgk;
      end else if (s_r.awaddr >= `BLDC_OFS_PRESET1 && s_r.awaddr <= `BLDC_OFS_PRESET4
                   && s_r.awaddr[1:0] == 2'h0) begin
        s_nxt.preset[s_r.awaddr[4:2] - 3'h2] =
          merge_bytes(s_r.preset[s_r.awaddr[4:2] - 3'h2], s_r.wdata, s_r.wstrb);
      end else if (s_r.awaddr == `BLDC_OFS_MULT) begin
        s_nxt.mult = merge_bytes(s_r.mult, s_r.wdata, s_r.wstrb);
      end else if (s_r.awaddr == `BLDC_OFS_DIV) begin
        s_nxt.div = merge_bytes(s_r.div, s_r.wdata, s_r.wstrb);
      end else if (s_r.awaddr == `BLDC_OFS_CORE) begin
        s_nxt.core = merge_bytes(s_r.core, s_r.wdata, s_r.wstrb);
      end else if (s_r.awaddr == `BLDC_OFS_CMD) begin
        do_reset = s_r.wstrb[0] & s_r.wdata[`BLDC_CMD_RESET];
      end else if (s_r.awaddr == `BLDC_OFS_MASTER || s_r.awaddr == `BLDC_OFS_VALUE
                   || s_r.awaddr == `BLDC_OFS_MIN || s_r.awaddr == `BLDC_OFS_MAX
                   || s_r.awaddr == `BLDC_OFS_STATUS || s_r.awaddr == `BLDC_OFS_REVCNT) begin
        s_nxt.bresp = `BLDC_RESP_OKAY;
      end else begin
        s_nxt.bresp = `BLDC_RESP_SLVERR;
      end
    end

    // A reset command clears the counts (reversed batch mode loads master from preset one) and restarts extreme tracking.
    if (do_reset) begin
      s_nxt.master    = (batch_mode && s_r.rev) ? s_r.preset[0] : 32'h00000000;
      s_nxt.batch     = 32'h00000000;
      s_nxt.latched   = 32'h00000000;
      s_nxt.diam      = 32'h00000000;
      s_nxt.line_last = 32'h00000000;
      s_nxt.mm_valid  = 1'b0;
      s_nxt.running   = 1'b0;
    end

    // Scaling operands take their diameter values on mode entry.
    if (s_nxt.mode == `BLDC_MODE_DIAM && s_r.mode != `BLDC_MODE_DIAM) begin
      s_nxt.mult = `BLDC_DIAM_MULT_DEF;
      s_nxt.div  = `BLDC_DIAM_DIV_DEF;
    end

    // Read channel.
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (rd_do) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `BLDC_RESP_OKAY;
      if (s_axi_araddr == `BLDC_OFS_CTRL) begin
        s_nxt.rdata = {20'h00000, s_r.startstop, s_r.edge2_fall, s_r.edge1_fall, s_r.rev,
                       1'b0, s_r.restart, s_r.mode};
      end else if (s_axi_araddr == `BLDC_OFS_ASSIGN) begin
        s_nxt.rdata = {8'h00, s_r.asgk, s_r.asg2, s_r.asg1};
      end else if (s_axi_araddr >= `BLDC_OFS_PRESET1 && s_axi_araddr <= `BLDC_OFS_PRESET4
                   && s_axi_araddr[1:0] == 2'h0) begin
        s_nxt.rdata = s_r.preset[s_axi_araddr[4:2] - 3'h2];
      end else if (s_axi_araddr == `BLDC_OFS_MULT) begin
        s_nxt.rdata = s_r.mult;
      end else if (s_axi_araddr == `BLDC_OFS_DIV) begin
        s_nxt.rdata = s_r.div;
      end else if (s_axi_araddr == `BLDC_OFS_CORE) begin
        s_nxt.rdata = s_r.core;
      end else if (s_axi_araddr == `BLDC_OFS_CMD) begin
        s_nxt.rdata = 32'h00000000;
      end else if (s_axi_araddr == `BLDC_OFS_MASTER) begin
        s_nxt.rdata = s_r.master;
      end else if (s_axi_araddr == `BLDC_OFS_VALUE) begin
        s_nxt.rdata = tracked;
      end else if (s_axi_araddr == `BLDC_OFS_MIN) begin
        s_nxt.rdata = s_r.minv;
      end else if (s_axi_araddr == `BLDC_OFS_MAX) begin
        s_nxt.rdata = s_r.maxv;
      end else if (s_axi_araddr == `BLDC_OFS_STATUS) begin
        s_nxt.rdata = status_w;
      end else if (s_axi_araddr == `BLDC_OFS_REVCNT) begin
        s_nxt.rdata = s_r.rev_count;
      end else begin
        s_nxt.rdata = 32'h00000000;
        s_nxt.rresp = `BLDC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready            = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready             = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid             = s_r.bvalid;
  assign s_axi_bresp              = s_r.bresp;
  assign s_axi_arready            = !s_r.rvalid;
  assign s_axi_rvalid             = s_r.rvalid;
  assign s_axi_rdata              = s_r.rdata;
  assign s_axi_rresp              = s_r.rresp;
  assign rev_count                = s_r.rev_count;
  assign rev_strobe               = s_r.rev_strobe;
  assign final_scaling_multiplier = s_r.mult;
  assign final_scaling_divider    = s_r.div;
  assign preset_output_one        = s_r.kout[0];
  assign preset_output_two        = s_r.kout[1];
  assign preset_output_three      = s_r.kout[2];
  assign preset_output_four       = s_r.kout[3];

endmodule  // bldc_counter
`default_nettype wire

// File: hw/bldc_defines.svh
// Purpose: Offsets, field positions, diameter scaling defaults and timing counts of the counter block.
// Assumes: 32-bit AXI4-Lite register space, one aligned word per register.
// Notes:   Definitions only; included by the counter module and the bench.
//
// Overview of operation
// - Mode 3 counts encoder one only.
// - Batch restart needs restart option 2 or 4.
// - Master at preset: clear master, batch plus one.
// - Input assigned code 13 decrements batch.
// - Batch mode keeps batch minimum and maximum.
// - Batch mode: comparators 1,2 master; 3,4 batch.
// - Reversed sense: load preset, count down, reload.
// - Mode 4 counts encoder one as length.
// - Length result latched while live counter continues.
// - Control inputs start/stop, edges separately configurable.
// - Input one edge latches length and resets.
// - Input one starts, input two stops and latches.
// - Length mode always restarts from zero.
// - Length mode keeps minimum and maximum lengths.
// - Length mode: comparators 1,2 live; 3,4 latched.
// - Mode 5 counts lines, one trigger per revolution.
// - Diameter display changes only on new results.
// - Entering mode 5 loads diameter scaling operands.
// - Nonzero core setting is subtracted from diameter.
// - Diameter mode keeps minimum and maximum diameter.
// - Diameter mode: comparators 1,2 lines; 3,4 diameter.
// - Extremes are sampled once per millisecond.
`ifndef BLDC_DEFINES_SVH
`define BLDC_DEFINES_SVH

`define BLDC_OFS_CTRL    8'h00
`define BLDC_OFS_ASSIGN  8'h04
`define BLDC_OFS_PRESET1 8'h08
`define BLDC_OFS_PRESET2 8'h0C
`define BLDC_OFS_PRESET3 8'h10
`define BLDC_OFS_PRESET4 8'h14
`define BLDC_OFS_MULT    8'h18
`define BLDC_OFS_DIV     8'h1C
`define BLDC_OFS_CORE    8'h20
`define BLDC_OFS_CMD     8'h24
`define BLDC_OFS_MASTER  8'h28
`define BLDC_OFS_VALUE   8'h2C
`define BLDC_OFS_MIN     8'h30
`define BLDC_OFS_MAX     8'h34
`define BLDC_OFS_STATUS  8'h38
`define BLDC_OFS_REVCNT  8'h3C

`define BLDC_CTRL_MODE_LSB    0
`define BLDC_CTRL_RESTART_LSB 4
`define BLDC_CTRL_REVERSE     8
`define BLDC_CTRL_EDGE1_FALL  9
`define BLDC_CTRL_EDGE2_FALL  10
`define BLDC_CTRL_STARTSTOP   11
`define BLDC_CMD_RESET        0

`define BLDC_MODE_BATCH  4'h3
`define BLDC_MODE_LENGTH 4'h4
`define BLDC_MODE_DIAM   4'h5
`define BLDC_RESTART_A   3'h2
`define BLDC_RESTART_B   3'h4
`define BLDC_CMD_BATCH_DEC 8'h0D

`define BLDC_DIAM_MULT_DEF 32'h00002710
`define BLDC_DIAM_DIV_DEF  32'h00007AB8

`define BLDC_RESP_OKAY   2'h0
`define BLDC_RESP_SLVERR 2'h2

`define BLDC_CLK_HZ      20000000
`define BLDC_TICK_MS     1
`define BLDC_TICK_CYCLES ((`BLDC_TICK_MS * `BLDC_CLK_HZ) / 1000)

`endif

// File: hw/bldc_pkg.sv
// Purpose: Types shared by the counter block.
// Assumes: Constants come from bldc_defines.svh.
// Notes:   The whole module state is one packed struct.
`default_nettype none
package bldc_pkg;

  typedef struct packed {
    logic [3:0]        mode;
    logic [2:0]        restart;
    logic              rev;
    logic              edge1_fall;
    logic              edge2_fall;
    logic              startstop;
    logic [7:0]        asg1;
    logic [7:0]        asg2;
    logic [7:0]        asgk;
    logic [3:0][31:0]  preset;
    logic [31:0]       mult;
    logic [31:0]       div;
    logic [31:0]       core;
    logic [31:0]       master;
    logic [31:0]       batch;
    logic [31:0]       latched;
    logic [31:0]       diam;
    logic [31:0]       line_last;
    logic [31:0]       rev_count;
    logic              rev_strobe;
    logic [31:0]       minv;
    logic [31:0]       maxv;
    logic              mm_valid;
    logic              running;
    logic [31:0]       tick;
    logic              prev_c1;
    logic              prev_c2;
    logic              prev_key;
    logic              prev_trig;
    logic [3:0]        kout;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } bldc_state_t;

endpackage
`default_nettype wire

// File: verification/bldc_counter_properties.sv
// Purpose: Port checks of the counter block.
// Assumes: Synchronous active-low reset.
// Notes:   Bound to bldc_counter after the module.
`default_nettype none
module bldc_counter_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        rev_strobe,
  input wire logic [31:0] rev_count
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data withdrawn");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  strobe_pulse_a: assert property (rev_strobe |=> !rev_strobe)
    else $error("revolution strobe too long");
  count_change_a: assert property ($changed(rev_count) |-> rev_strobe)
    else $error("line count changed without strobe");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_rev: cover property (rev_strobe);
endmodule // bldc_counter_properties
bind bldc_counter bldc_counter_properties i_bldc_counter_properties (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .rev_strobe(rev_strobe), .rev_count(rev_count));
`default_nettype wire

// File: verification/bldc_source_model.sv
// Purpose: Encoder, sensor and diameter unit facing the counter.
// Assumes: The bench steers it through its tasks.
// Notes:   A diameter result follows each revolution strobe.
`default_nettype none
module bldc_source_model (
  input  wire logic        aclk,
  input  wire logic        rev_strobe,
  output logic             enc1_step,
  output logic             enc1_down,
  output logic             enc2_step,
  output logic [3:0]       sens,
  output logic             diam_valid,
  output logic [31:0]      diam_full
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] dval;
  initial begin
    {enc1_step, enc1_down, enc2_step, diam_valid} = '0;
    sens = '0;
    diam_full = '0;
    dval = '0;
  end
  // The second encoder chatters all the time.
  always @(posedge aclk) enc2_step <= ~enc2_step;
  // The result stands one cycle; then the bus carries junk.
  always @(posedge aclk) begin
    diam_valid <= rev_strobe;
    diam_full <= rev_strobe ? dval : ~diam_full;
  end
  task automatic steps(input int n);
    repeat (n) begin
      @(posedge aclk);
      enc1_step <= 1'b1;
      @(posedge aclk);
      enc1_step <= 1'b0;
    end
  endtask
  task automatic down(input int n);
    enc1_down <= 1'b1;
    steps(n);
    enc1_down <= 1'b0;
  endtask
  task automatic pins(input logic [3:0] s);
    @(posedge aclk);
    sens <= s;
    repeat (3) @(posedge aclk);
  endtask
endmodule // bldc_source_model
`default_nettype wire

// File: verification/bldc_counter_tb.sv
// Purpose: Self-checking bench of the counter block.
// Assumes: Tick shortened to 8 cycles.
// Notes:   Sensor order in pins is input one, input two, key, trigger.
`include "bldc_defines.svh"
`default_nettype none
module bldc_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awv, awrdy, wv, wrdy, bv, brd, arv, ardy, rv, rrd;
  logic        e1, e1d, e2, dv, rs, p1, p2, p3, p4;
  logic [1:0]  rresp, rr, bresp, br;
  logic [3:0]  wstrb, s;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, dfull, rcnt, mul, dvr, v;
  int          n_mismatch, num_checks;
  bldc_counter #(.TICK_CYCLES(8)) i_bldc_counter (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(ardy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrd), .enc1_step(e1), .enc1_down(e1d), .enc2_step(e2),
    .control_input_one(s[3]), .control_input_two(s[2]), .key_input(s[1]),
    .roll_trigger(s[0]), .diam_valid(dv), .diam_full(dfull), .rev_count(rcnt),
    .rev_strobe(rs), .final_scaling_multiplier(mul), .final_scaling_divider(dvr),
    .preset_output_one(p1), .preset_output_two(p2), .preset_output_three(p3),
    .preset_output_four(p4));
  bldc_source_model i_bldc_source_model (.aclk(aclk), .rev_strobe(rs), .enc1_step(e1),
    .enc1_down(e1d), .enc2_step(e2), .sens(s), .diam_valid(dv), .diam_full(dfull));
  always #25 aclk = ~aclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    do begin
      @(posedge aclk);
      awv <= awv && !awrdy;
      wv <= wv && !wrdy;
    end while ((awv && !awrdy) || (wv && !wrdy));
    do @(posedge aclk); while (!bv);
    br = bresp;
    brd <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do @(posedge aclk); while (!ardy);
    arv <= 1'b0;
    do @(posedge aclk); while (!rv);
    v = rdata;
    rr = rresp;
    rrd <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, v);
  endtask
  task automatic t_bus;
    rc("ctrl", `BLDC_OFS_CTRL, 32'h0);
    rc("unmapped", 8'h40, 32'h0);
    chk("unmapped resp", {30'h0, `BLDC_RESP_SLVERR}, {30'h0, rr});
    wr(`BLDC_OFS_MASTER, 32'h55);
    chk("ro wresp", {30'h0, `BLDC_RESP_OKAY}, {30'h0, br});
    rc("read only", `BLDC_OFS_MASTER, 32'h0);
    wr(8'h40, 32'h1);
    chk("unmapped wresp", {30'h0, `BLDC_RESP_SLVERR}, {30'h0, br});
    wstrb <= 4'h3;
    wr(`BLDC_OFS_MULT, 32'h12345678);
    wstrb <= 4'hF;
    rc("strobe", `BLDC_OFS_MULT, 32'h00005678);
    $display("t_bus done");
  endtask
  task automatic t_batch;
    wr(`BLDC_OFS_PRESET1, 32'h5);
    wr(`BLDC_OFS_PRESET2, 32'h2);
    wr(`BLDC_OFS_PRESET3, 32'h2);
    wr(`BLDC_OFS_PRESET4, 32'h3);
    wr(`BLDC_OFS_CTRL, 32'h23);
    i_bldc_source_model.steps(12);
    rc("master", `BLDC_OFS_MASTER, 32'h2);
    rc("batch", `BLDC_OFS_VALUE, 32'h2);
    chk("outputs", 32'h6, {28'h0, p4, p3, p2, p1});
    wr(`BLDC_OFS_ASSIGN, 32'h000D0000);
    i_bldc_source_model.pins(4'b0010);
    rc("batch dec", `BLDC_OFS_VALUE, 32'h1);
    repeat (20) @(posedge aclk);
    rc("batch max", `BLDC_OFS_MAX, 32'h2);
    rc("batch min", `BLDC_OFS_MIN, 32'h0);
    wr(`BLDC_OFS_CMD, 32'h1);
    rc("cleared", `BLDC_OFS_MASTER, 32'h0);
    rc("batch cleared", `BLDC_OFS_VALUE, 32'h0);
    wr(`BLDC_OFS_CTRL, 32'h143);
    i_bldc_source_model.steps(6);
    rc("reload", `BLDC_OFS_MASTER, 32'h5);
    rc("batch up", `BLDC_OFS_VALUE, 32'h2);
    $display("t_batch done");
  endtask
  task automatic t_length;
    wr(`BLDC_OFS_CTRL, 32'h4);
    wr(`BLDC_OFS_CMD, 32'h1);
    i_bldc_source_model.steps(7);
    i_bldc_source_model.pins(4'b1000);
    i_bldc_source_model.steps(3);
    rc("live", `BLDC_OFS_MASTER, 32'h3);
    rc("frozen", `BLDC_OFS_VALUE, 32'h7);
    chk("outputs", 32'hE, {28'h0, p4, p3, p2, p1});
    wr(`BLDC_OFS_CTRL, 32'hC04);
    i_bldc_source_model.pins(4'b0000);
    i_bldc_source_model.pins(4'b1100);
    i_bldc_source_model.steps(4);
    i_bldc_source_model.pins(4'b0000);
    rc("gap", `BLDC_OFS_VALUE, 32'h4);
    rc("len max", `BLDC_OFS_MAX, 32'h7);
    $display("t_length done");
  endtask
  task automatic t_diam;
    wr(`BLDC_OFS_CORE, 32'h10);
    wr(`BLDC_OFS_CTRL, 32'h5);
    chk("mult", `BLDC_DIAM_MULT_DEF, mul);
    chk("div", `BLDC_DIAM_DIV_DEF, dvr);
    wr(`BLDC_OFS_PRESET4, 32'hF0);
    i_bldc_source_model.dval = 32'h100;
    i_bldc_source_model.pins(4'b0001);
    i_bldc_source_model.steps(6);
    i_bldc_source_model.pins(4'b0000);
    i_bldc_source_model.pins(4'b0001);
    chk("lines", 32'h6, rcnt);
    rc("remaining", `BLDC_OFS_VALUE, 32'hF0);
    chk("outputs", 32'h3, {30'h0, p4, p3});
    wr(`BLDC_OFS_CORE, 32'h0);
    i_bldc_source_model.pins(4'b0000);
    i_bldc_source_model.pins(4'b0001);
    rc("full", `BLDC_OFS_VALUE, 32'h100);
    repeat (20) @(posedge aclk);
    rc("diam max", `BLDC_OFS_MAX, 32'h100);
    i_bldc_source_model.down(3);
    rc("down", `BLDC_OFS_MASTER, 32'h7);
    $display("t_diam done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {aclk, aresetn, awv, wv, brd, arv, rrd} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_bus();
    t_batch();
    t_length();
    t_diam();
    report_and_stop();
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    report_and_stop();
  end
endmodule // bldc_counter_tb
`default_nettype wire
